// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk_i;
  logic rst_i;
  logic [6:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [13:0] drive_level_o;
  logic [pdfs_pkg::PDFS_FSEL_REGS-1:0][7:0] func_sel_o;
  logic [pdfs_pkg::PDFS_PINS-1:0] gpio_out_i, alt1_out_i, alt2_out_i, pin_out_o;
  logic [pdfs_pkg::PDFS_CAPS-1:0] cap_pin_a_i, cap_pin_b_i, cap_o;
  int errors;
  int cmp_count;
  logic [31:0] exp_q[$];
  logic [7:0] mdl [0:31];

  pdfs_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .drive_level_o(drive_level_o),
    .func_sel_o(func_sel_o), .gpio_out_i(gpio_out_i), .alt1_out_i(alt1_out_i),
    .alt2_out_i(alt2_out_i), .pin_out_o(pin_out_o), .cap_pin_a_i(cap_pin_a_i),
    .cap_pin_b_i(cap_pin_b_i), .cap_o(cap_o)
  );

  // 20 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // one compare point for every result
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bits that a register really stores
  function automatic logic [7:0] fmask(input logic [4:0] idx);
    if (idx == pdfs_pkg::PDFS_IDX_IFS) return pdfs_pkg::PDFS_IFS_MASK;
    if (idx == pdfs_pkg::PDFS_IDX_FSEL + 5'(pdfs_pkg::PDFS_FSEL_PE_LO)) begin
      return pdfs_pkg::PDFS_PE_LO_MASK;
    end
    return 8'hff;
  endfunction

  // avalon request held until waitrequest is sampled low, one idle edge after
  task automatic bus_op(input logic wr, input logic [4:0] idx, input logic [7:0] data,
                        input logic [3:0] be);
    int n;
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'($urandom), data};
    avs_byteenable_i <= be;
    if (!wr) exp_q.push_back({24'h0, mdl[idx]});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      summarize();
    end
    if (wr && idx <= pdfs_pkg::PDFS_IDX_IFS && be[0]) mdl[idx] = data & fmask(idx);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // read answers are compared against the oldest note
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED at %0t: unexpected read answer", $time);
      end else begin
        check(avs_readdata_o, exp_q.pop_front(), "read data");
      end
    end
  end

  // reset, then outputs and every register must read zero
  task automatic reset_and_check();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    // sampled while reset still holds drive, pin and selection outputs cleared
    check(drive_level_o, 64'h0, "drive after reset");
    check(pin_out_o, 64'h0, "pins after reset");
    for (int i = 0; i < pdfs_pkg::PDFS_FSEL_REGS; i++) begin
      check(func_sel_o[i], 64'h0, "selection after reset");
    end
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
    for (int i = 0; i < 17; i++) bus_op(1'b0, 5'(i), 8'h00, 4'hf);
  endtask

  // random sources, pin outputs follow the selected code of each pin
  task automatic check_pins();
    logic [63:0] exp;
    logic [7:0] r;
    logic [1:0] code;
    gpio_out_i <= 56'({$urandom, $urandom});
    alt1_out_i <= 56'({$urandom, $urandom});
    alt2_out_i <= 56'({$urandom, $urandom});
    repeat (3) @(posedge clk_i);
    exp = '0;
    for (int n = 0; n < pdfs_pkg::PDFS_PINS; n++) begin
      r = mdl[2 + (n / 8) * 2 + (n % 8) / 4];
      code = r[2 * (n % 4) +: 2];
      exp[n] = (code == pdfs_pkg::PDFS_CODE_ALT2) ? alt2_out_i[n] :
               (code == pdfs_pkg::PDFS_CODE_ALT1) ? alt1_out_i[n] : gpio_out_i[n];
    end
    check(pin_out_o, exp, "pin output");
    for (int i = 0; i < pdfs_pkg::PDFS_FSEL_REGS; i++) begin
      check(func_sel_o[i], mdl[2 + i], "selection slot");
    end
    // peripherals released before the next selection rewrite
    alt1_out_i <= '0;
    alt2_out_i <= '0;
  endtask

  initial begin
    #2500000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end

  // main sequence
  initial begin
    void'($urandom(35));
    rst_i = 1'b1;
    avs_address_i = 7'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    gpio_out_i = '0;
    alt1_out_i = '0;
    alt2_out_i = '0;
    cap_pin_a_i = '0;
    cap_pin_b_i = '0;
    @(posedge clk_i);
    reset_and_check();
    // random write and readback, unmapped and masked places included
    for (int i = 0; i < 21; i++) bus_op(1'b1, 5'(i), 8'($urandom), 4'h1 | 4'($urandom));
    for (int i = 0; i < 21; i++) bus_op(1'b0, 5'(i), 8'h00, 4'hf);
    bus_op(1'b0, 5'h1f, 8'h00, 4'hf);
    bus_op(1'b1, 5'h03, ~mdl[3], 4'he);
    bus_op(1'b0, 5'h03, 8'h00, 4'hf);
    // walk one drive bit over both registers, spare bits random
    for (int b = 0; b < 14; b++) begin
      logic [13:0] lvl;
      lvl = 14'h1 << b;
      bus_op(1'b1, pdfs_pkg::PDFS_IDX_DRV0, lvl[7:0], 4'hf);
      bus_op(1'b1, pdfs_pkg::PDFS_IDX_DRV1, {2'($urandom), lvl[13:8]}, 4'h1);
      check(drive_level_o, lvl, "drive level");
      bus_op(1'b0, pdfs_pkg::PDFS_IDX_DRV1, 8'h00, 4'hf);
    end
    // every code on every pin except the masked port e field (bits 3:2 of slot 8), then a random mix
    for (int c = 0; c < 5; c++) begin
      for (int i = 0; i < pdfs_pkg::PDFS_FSEL_REGS; i++) begin
        bus_op(1'b1, 5'(2 + i), (c < 4) ? {4{2'(c)}} : 8'($urandom), 4'hf);
      end
      check_pins();
    end
    // capture inputs follow the route bit of each timer
    for (int k = 0; k < 4; k++) begin
      bus_op(1'b1, pdfs_pkg::PDFS_IDX_IFS, 8'($urandom), 4'hf);
      cap_pin_a_i <= 6'($urandom);
      cap_pin_b_i <= 6'($urandom);
      repeat (5) @(posedge clk_i);
      check(cap_o, (cap_pin_b_i & mdl[16][5:0]) | (cap_pin_a_i & ~mdl[16][5:0]),
            "capture route");
    end
    reset_and_check();
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule

// [logic/pdfs_in_route.sv]
`timescale 1ns/10ps
module pdfs_in_route (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [pdfs_pkg::PDFS_CAPS-1:0] route_sel_i,
  input wire logic [pdfs_pkg::PDFS_CAPS-1:0] pin_a_i,
  input wire logic [pdfs_pkg::PDFS_CAPS-1:0] pin_b_i,
  output logic [pdfs_pkg::PDFS_CAPS-1:0] cap_o
);

  pdfs_pkg::pdfs_route_st_t st_r;
  pdfs_pkg::pdfs_route_st_t st_nxt;

  // two-stage sync of both candidate pins, then pick by route bit
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1a = pin_a_i;
    st_nxt.s2a = st_r.s1a;
    st_nxt.s1b = pin_b_i;
    st_nxt.s2b = st_r.s1b;
    st_nxt.cap = (st_r.s2b & route_sel_i) | (st_r.s2a & ~route_sel_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cap_o = st_r.cap;

  route_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    route_sel_i[0] |=> cap_o[0] == $past(pin_b_i[0], 3))
    else $error("capture input 0 not taken from the alternate pin");

endmodule

// [logic/pdfs_out_mux.sv]
`timescale 1ns/10ps
module pdfs_out_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0][1:0] sel_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] gpio_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] alt1_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] alt2_i,
  output logic [pdfs_pkg::PDFS_PINS-1:0] pin_o
);

  pdfs_pkg::pdfs_mux_st_t st_r;
  pdfs_pkg::pdfs_mux_st_t st_nxt;

  // codes 00 and 01 keep general i/o
  function automatic logic pick(input logic [1:0] c, input logic g, input logic a1,
                                input logic a2);
    case (c)
      pdfs_pkg::PDFS_CODE_ALT1: pick = a1;
      pdfs_pkg::PDFS_CODE_ALT2: pick = a2;
      default: pick = g;
    endcase
  endfunction

  // per-pin source choice from the selection field only
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < pdfs_pkg::PDFS_PINS; i++) begin
      st_nxt.pin[i] = pick(sel_i[i], gpio_i[i], alt1_i[i], alt2_i[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_o = st_r.pin;

  mux_alt1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i[0] == pdfs_pkg::PDFS_CODE_ALT1 |=> pin_o[0] == $past(alt1_i[0]))
    else $error("pin 0 does not carry the first alternate function");

endmodule

// [logic/pdfs_pkg.sv]
package pdfs_pkg;

  // sizes of the pin bank
  localparam int PDFS_PINS = 56;
  localparam int PDFS_CAPS = 6;
  localparam int PDFS_FSEL_REGS = 14;

  // register word indexes, byte address is four times the index
  localparam logic [4:0] PDFS_IDX_DRV0 = 5'h00;
  localparam logic [4:0] PDFS_IDX_DRV1 = 5'h01;
  localparam logic [4:0] PDFS_IDX_FSEL = 5'h02;
  localparam logic [4:0] PDFS_IDX_IFS = 5'h10;
  localparam logic [3:0] PDFS_FSEL_PE_LO = 4'h8;

  // field layout
  localparam int PDFS_DRV1_LVL_W = 6;
  localparam int PDFS_SPARE_POS = 6;
  localparam logic [7:0] PDFS_PE_LO_MASK = 8'hf3;
  localparam logic [7:0] PDFS_IFS_MASK = 8'h3f;

  // reset values
  localparam logic [7:0] PDFS_DRV_RST = 8'h00;
  localparam logic [7:0] PDFS_FSEL_RST = 8'h00;
  localparam logic [5:0] PDFS_IFS_RST = 6'h00;

  // function codes of a pin field
  localparam logic [1:0] PDFS_CODE_ALT1 = 2'h2;
  localparam logic [1:0] PDFS_CODE_ALT2 = 2'h3;

  typedef enum logic [1:0] {
    PDFS_IDLE = 2'b01,
    PDFS_ACK = 2'b10
  } pdfs_bus_st_t;

  typedef struct packed {
    pdfs_bus_st_t bus_st;
    logic waitreq;
    logic [7:0] rdata;
    logic [7:0] drv0;
    logic [7:0] drv1;
    logic [PDFS_FSEL_REGS-1:0][7:0] func_sel;
    logic [5:0] input_route_select;
  } pdfs_state_t;

  localparam pdfs_state_t PDFS_ST_RST = '{
    bus_st: PDFS_IDLE,
    waitreq: 1'b1,
    rdata: 8'h00,
    drv0: PDFS_DRV_RST,
    drv1: PDFS_DRV_RST,
    func_sel: {PDFS_FSEL_REGS{PDFS_FSEL_RST}},
    input_route_select: PDFS_IFS_RST
  };

  typedef struct packed {
    logic [PDFS_CAPS-1:0] s1a;
    logic [PDFS_CAPS-1:0] s2a;
    logic [PDFS_CAPS-1:0] s1b;
    logic [PDFS_CAPS-1:0] s2b;
    logic [PDFS_CAPS-1:0] cap;
  } pdfs_route_st_t;

  typedef struct packed {
    logic [PDFS_PINS-1:0] pin;
  } pdfs_mux_st_t;

endpackage

// [logic/pdfs_top.sv]
`timescale 1ns/10ps
// What this block does
// - drive bits 0,1 set port A nibbles
// - drive bit 2 sets port B low nibble
// - bit clear minimum, bit set maximum drive
// - second drive bit 5 sets port G high
// - pin function chosen only by selection registers
// - per-port output selects plus one input select
// - input select routes capture inputs from pins
// - one drive bit per four-pin group
// - two-bit field per pin, 10/11 alternate
module pdfs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [13:0] drive_level_o,
  output logic [pdfs_pkg::PDFS_FSEL_REGS-1:0][7:0] func_sel_o,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] gpio_out_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] alt1_out_i,
  input wire logic [pdfs_pkg::PDFS_PINS-1:0] alt2_out_i,
  output logic [pdfs_pkg::PDFS_PINS-1:0] pin_out_o,
  input wire logic [pdfs_pkg::PDFS_CAPS-1:0] cap_pin_a_i,
  input wire logic [pdfs_pkg::PDFS_CAPS-1:0] cap_pin_b_i,
  output logic [pdfs_pkg::PDFS_CAPS-1:0] cap_o
);

  pdfs_pkg::pdfs_state_t st_r;
  pdfs_pkg::pdfs_state_t st_nxt;
  logic [4:0] idx;
  logic acc_wr;
  logic idle_rd;

  // selection register slot of a word index
  function automatic logic [3:0] fsel_slot(input logic [4:0] i);
    logic [4:0] k;
    k = i - pdfs_pkg::PDFS_IDX_FSEL;
    fsel_slot = k[3:0];
  endfunction

  // true for the word indexes of the selection registers
  function automatic logic is_fsel(input logic [4:0] i);
    is_fsel = (i >= pdfs_pkg::PDFS_IDX_FSEL) && (i < pdfs_pkg::PDFS_IDX_IFS);
  endfunction

  // read value of a word index, unmapped words read zero
  function automatic logic [7:0] rd_val(input pdfs_pkg::pdfs_state_t s,
                                        input logic [4:0] i);
    rd_val = 8'h00;
    if (i == pdfs_pkg::PDFS_IDX_DRV0) begin
      rd_val = s.drv0;
    end else if (i == pdfs_pkg::PDFS_IDX_DRV1) begin
      rd_val = s.drv1;
    end else if (is_fsel(i)) begin
      rd_val = s.func_sel[fsel_slot(i)];
    end else if (i == pdfs_pkg::PDFS_IDX_IFS) begin
      rd_val = {2'b00, s.input_route_select};
    end
  endfunction

  // implemented bits of a selection register
  function automatic logic [7:0] fsel_mask(input logic [3:0] slot);
    if (slot == pdfs_pkg::PDFS_FSEL_PE_LO) begin
      fsel_mask = pdfs_pkg::PDFS_PE_LO_MASK;
    end else begin
      fsel_mask = 8'hff;
    end
  endfunction

  // word index and access qualifiers of the current request
  assign idx = avs_address_i[6:2];
  assign acc_wr = (st_r.bus_st == pdfs_pkg::PDFS_ACK) && avs_write_i && avs_byteenable_i[0];
  assign idle_rd = (st_r.bus_st == pdfs_pkg::PDFS_IDLE) && avs_read_i;

  // bus handshake and register writes
  always_comb begin
    st_nxt = st_r;
    case (st_r.bus_st)
      pdfs_pkg::PDFS_IDLE: begin
        st_nxt.waitreq = 1'b1;
        if (avs_read_i || avs_write_i) begin
          st_nxt.bus_st = pdfs_pkg::PDFS_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.rdata = avs_read_i ? rd_val(st_r, idx) : 8'h00;
        end
      end
      pdfs_pkg::PDFS_ACK: begin
        st_nxt.bus_st = pdfs_pkg::PDFS_IDLE;
        st_nxt.waitreq = 1'b1;
        // write lands at the edge where waitrequest is seen low
        if (acc_wr) begin
          if (idx == pdfs_pkg::PDFS_IDX_DRV0) begin
            st_nxt.drv0 = avs_writedata_i[7:0];
          end else if (idx == pdfs_pkg::PDFS_IDX_DRV1) begin
            st_nxt.drv1 = avs_writedata_i[7:0];
          end else if (is_fsel(idx)) begin
            st_nxt.func_sel[fsel_slot(idx)] =
              avs_writedata_i[7:0] & fsel_mask(fsel_slot(idx));
          end else if (idx == pdfs_pkg::PDFS_IDX_IFS) begin
            st_nxt.input_route_select = avs_writedata_i[5:0] & pdfs_pkg::PDFS_IFS_MASK[5:0];
          end
        end
      end
      default: begin
        st_nxt.bus_st = pdfs_pkg::PDFS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase
  end

  // state register, reset clears the data fields and rdata, raises waitreq and enters PDFS_IDLE
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= pdfs_pkg::PDFS_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus answer
  assign avs_readdata_o = {24'h000000, st_r.rdata};
  assign avs_waitrequest_o = st_r.waitreq;

  // one level bit per nibble, ports a..d then e..g
  assign drive_level_o = {st_r.drv1[pdfs_pkg::PDFS_DRV1_LVL_W-1:0], st_r.drv0};
  assign func_sel_o = st_r.func_sel;

  // output function mux for every pin
  pdfs_out_mux u_out_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(st_r.func_sel),
    .gpio_i(gpio_out_i),
    .alt1_i(alt1_out_i),
    .alt2_i(alt2_out_i),
    .pin_o(pin_out_o)
  );

  // capture inputs routed from one of two pins
  pdfs_in_route u_in_route (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .route_sel_i(st_r.input_route_select),
    .pin_a_i(cap_pin_a_i),
    .pin_b_i(cap_pin_b_i),
    .cap_o(cap_o)
  );

  // checks on the handshake and the stored fields
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  req_answer_a: assert property (
    (avs_read_i || avs_write_i) && st_r.bus_st == pdfs_pkg::PDFS_IDLE
    |=> !avs_waitrequest_o)
    else $error("request not answered in one cycle");

  drv_porta_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> drive_level_o[1:0] == $past(avs_writedata_i[1:0]))
    else $error("port a drive levels not taken from bits 1:0");

  drv_portb_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> drive_level_o[2] == $past(avs_writedata_i[2]))
    else $error("port b low nibble drive not taken from bit 2");

  drv_max_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1 && avs_writedata_i[0]
    |=> drive_level_o[8] ##1 drive_level_o[8])
    else $error("set bit does not give maximum drive");

  spare_store_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> st_r.drv1[7:6] == $past(avs_writedata_i[7:6])
        && drive_level_o[13:8] == $past(avs_writedata_i[5:0]))
    else $error("spare bits not stored or leak into drive");

  drv_portg_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> drive_level_o[13] == $past(avs_writedata_i[5]))
    else $error("port g high nibble drive not taken from bit 5");

  fsel_hold_a: assert property (
    !acc_wr |=> $stable(func_sel_o) && $stable(st_r.input_route_select))
    else $error("selection changed without a register write");

  fsel_write_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_FSEL
    |=> func_sel_o[0] == $past(avs_writedata_i[7:0]))
    else $error("port a low selection not written");

  route_write_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_IFS
    |=> st_r.input_route_select == $past(avs_writedata_i[5:0]))
    else $error("input route select not written");

  pe_gap_a: assert property (
    idle_rd && idx == pdfs_pkg::PDFS_IDX_FSEL + 5'h08
    |=> avs_readdata_o[3:2] == 2'b00 && !avs_waitrequest_o)
    else $error("unimplemented port e field reads nonzero");

  rst_clear_a: assert property (
    $past(rst_i) |-> drive_level_o == 14'h0000 && func_sel_o == '0
      && st_r.input_route_select == 6'h00 && avs_waitrequest_o)
    else $error("fields not cleared by reset");

  rd_back_a: assert property (
    idle_rd && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> avs_readdata_o[7:0] == $past(st_r.drv1))
    else $error("second drive register reads back wrong");

  unmapped_rd_a: assert property (
    idle_rd && idx > pdfs_pkg::PDFS_IDX_IFS
    |=> avs_readdata_o == 32'h00000000)
    else $error("unmapped word does not read zero");

  drv_pbhi_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> drive_level_o[3] == $past(avs_writedata_i[3]))
    else $error("port b high nibble drive not taken from bit 3");

  drv_pc_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> drive_level_o[5:4] == $past(avs_writedata_i[5:4]))
    else $error("port c drive levels not taken from bits 5:4");

  drv_pd_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> drive_level_o[7:6] == $past(avs_writedata_i[7:6]))
    else $error("port d drive levels not taken from bits 7:6");

  drv_pe_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> drive_level_o[9:8] == $past(avs_writedata_i[1:0]))
    else $error("port e drive levels not taken from bits 1:0");

  drv_pf_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> drive_level_o[11:10] == $past(avs_writedata_i[3:2]))
    else $error("port f drive levels not taken from bits 3:2");

  drv_pglo_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1
    |=> drive_level_o[12] == $past(avs_writedata_i[4]))
    else $error("port g low nibble drive not taken from bit 4");

  drv_min_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV0 && !avs_writedata_i[0]
    |=> !drive_level_o[0])
    else $error("clear bit does not give minimum drive");

  drv_hold_a: assert property (
    !(acc_wr && (idx == pdfs_pkg::PDFS_IDX_DRV0 || idx == pdfs_pkg::PDFS_IDX_DRV1))
    |=> $stable(drive_level_o))
    else $error("drive level changed without a drive write");

  spare_hold_a: assert property (
    !(acc_wr && idx == pdfs_pkg::PDFS_IDX_DRV1)
    |=> $stable(st_r.drv1))
    else $error("second drive register changed without a write");

  drv0_read_a: assert property (
    idle_rd && idx == pdfs_pkg::PDFS_IDX_DRV0
    |=> avs_readdata_o[7:0] == $past(st_r.drv0))
    else $error("first drive register reads back wrong");

  fsel_read_a: assert property (
    idle_rd && idx == pdfs_pkg::PDFS_IDX_FSEL
    |=> avs_readdata_o[7:0] == $past(func_sel_o[0]))
    else $error("port a low selection reads back wrong");

  route_read_a: assert property (
    idle_rd && idx == pdfs_pkg::PDFS_IDX_IFS
    |=> avs_readdata_o == {26'h0, $past(st_r.input_route_select)})
    else $error("input route select reads back wrong");

  fsel_top_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_IFS - 5'h01
    |=> func_sel_o[13] == $past(avs_writedata_i[7:0]))
    else $error("port g high selection not written");

  pe_mask_a: assert property (
    acc_wr && idx == pdfs_pkg::PDFS_IDX_FSEL + 5'h08
    |=> func_sel_o[8] == ($past(avs_writedata_i[7:0]) & pdfs_pkg::PDFS_PE_LO_MASK))
    else $error("port e low selection keeps unimplemented bits");

  be_gate_a: assert property (
    st_r.bus_st == pdfs_pkg::PDFS_ACK && avs_write_i && !avs_byteenable_i[0]
    |=> $stable(func_sel_o) && $stable(drive_level_o)
        && $stable(st_r.drv1) && $stable(st_r.input_route_select))
    else $error("write without byte enable changed a register");

  unmapped_wr_a: assert property (
    acc_wr && idx > pdfs_pkg::PDFS_IDX_IFS
    |=> $stable(func_sel_o) && $stable(st_r.drv0)
        && $stable(st_r.drv1) && $stable(st_r.input_route_select))
    else $error("write to unmapped word changed a register");

  pin_gpio_a: assert property (
    func_sel_o[0][1:0] == 2'b01
    |=> pin_out_o[0] == $past(gpio_out_i[0]))
    else $error("pin 0 does not keep general io for code 01");

  pin_alt2_a: assert property (
    func_sel_o[0][1:0] == 2'b11
    |=> pin_out_o[0] == $past(alt2_out_i[0]))
    else $error("pin 0 does not carry the second alternate function");

  pin_hi_a: assert property (
    func_sel_o[1][1:0] == 2'b10
    |=> pin_out_o[4] == $past(alt1_out_i[4]))
    else $error("pin 4 does not carry the first alternate function");

  pin_last_a: assert property (
    func_sel_o[13][7:6] == 2'b10
    |=> pin_out_o[55] == $past(alt1_out_i[55]))
    else $error("pin 55 does not carry the first alternate function");

  cap_primary_a: assert property (
    !st_r.input_route_select[0] && !$past(rst_i) && !$past(rst_i, 2)
    |=> cap_o[0] == $past(cap_pin_a_i[0], 3))
    else $error("capture input 0 not taken from the primary pin");

  rst_pins_a: assert property (
    $past(rst_i) |-> pin_out_o == '0 && cap_o == '0)
    else $error("pin and capture outputs not cleared by reset");

  rst_rdata_a: assert property (
    $past(rst_i) |-> avs_readdata_o == 32'h00000000)
    else $error("read data not cleared by reset");

  ack_state_a: assert property (
    st_r.bus_st == pdfs_pkg::PDFS_ACK |-> !avs_waitrequest_o)
    else $error("answer state without waitrequest low");

endmodule
